// file: hdl/sep_top.sv
// serial eeprom select, output drive and status protect logic
`timescale 1ns/100ps
`include "sep_defs.svh"
// Functional notes
// - internal write cycle ends at most 5 ms after the committing select rise.
// - select low means selected; serial traffic counts only then.
// - select high gives standby unless a write cycle still runs.
// - a started write cycle runs to its end whatever select does.
// - select raised during a write cycle gives standby when it ends.
// - serial output floats whenever the device is deselected.
// - select rise after a valid write sequence starts the write cycle.
// - read bits leave on the serial output after falling clock edges.
// - status writes refused while protect pin low and honor bit set.
// - protect pin and honor bit affect status writes only.
// - protect pin high lets every function work, status writes too.
// - honor bit set and pin low during status write discards it.
// - protect pin falling after a write cycle began has no effect.
// - honor bit clear makes the protect pin ignored entirely.
// - pause low floats the output; pause high drives it again.
// - opcode, address and data bits are taken on rising clock edges.
// - opcodes eight bits msb first: 06 latch set, 01 status write, 05 read.
module sep_top #(
  parameter int unsigned WR_CYCLES = `SEP_TWC_CYCLES,
  parameter logic [7:0]  ST_INIT   = `SEP_ST_RESET
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic       wp_n,
  output logic            so_o,
  output logic            so_oe,
  output logic            standby,
  output logic            busy,
  output logic            array_write_go,
  output logic            status_refused,
  output logic [7:0]      status_o
);
  // ---------------- link side, clocked by the serial clock ----------------
  // frame-only counters clear with select high; frame results survive it so
  // the core can read them after the select rise, when the clock stands still
  logic       in_frame_r;
  logic       frame_tgl_r;
  logic [2:0] bit_r;
  logic [2:0] byte_r;
  logic [7:0] shreg_r;
  logic [7:0] op_r;
  logic [7:0] sdat_r;
  logic [7:0] stat_l1_r;
  logic [7:0] stat_l2_r;
  logic [7:0] stat_frz_r;
  logic [6:0] out_sh_r;
  logic       so_r;
  logic       drive_r;

  wire       act_rise  = hold_n;
  wire [2:0] bit_cur   = in_frame_r ? bit_r : 3'h0;
  wire [2:0] byte_cur  = in_frame_r ? byte_r : 3'h0;
  wire [7:0] shreg_nxt = {shreg_r[6:0], si};
  wire       byte_end  = (bit_cur == 3'h7);
  wire [2:0] byte_nxt  = (byte_end && byte_cur != `SEP_BYTES_MAX) ?
                         byte_cur + 3'h1 : byte_cur;
  wire       rd_phase  = (op_r == `SEP_OP_STAT_RD) && (byte_r != 3'h0);
  // power-up clears the frame logic as select high does, so it never starts unknown
  wire       frame_clr = cs_n || !rstn;

  always_ff @(posedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame_r <= 1'b0;
    end else if (act_rise) begin
      in_frame_r <= 1'b1;
    end
  end

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      frame_tgl_r <= 1'b0;
      bit_r       <= 3'h0;
      byte_r      <= 3'h0;
      shreg_r     <= 8'h00;
      op_r        <= 8'h00;
      sdat_r      <= 8'h00;
    end else if (!cs_n && act_rise) begin
      frame_tgl_r <= in_frame_r ? frame_tgl_r : !frame_tgl_r;
      bit_r       <= bit_cur + 3'h1;
      byte_r      <= byte_nxt;
      shreg_r     <= shreg_nxt;
      if (byte_end && byte_cur == 3'h0) begin
        op_r <= shreg_nxt;
      end
      if (byte_end && byte_cur == 3'h1) begin
        sdat_r <= shreg_nxt;
      end
    end
  end

  // status byte into the link domain, two stages before use
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      stat_l1_r <= 8'h00;
      stat_l2_r <= 8'h00;
    end else begin
      stat_l1_r <= stat_frz_r;
      stat_l2_r <= stat_l1_r;
    end
  end

  // output shifts on the falling edge, reloads at each byte boundary
  always_ff @(negedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      so_r     <= 1'b0;
      out_sh_r <= 7'h00;
      drive_r  <= 1'b0;
    end else if (hold_n && rd_phase) begin
      drive_r <= 1'b1;
      if (bit_r == 3'h0) begin
        so_r     <= stat_l2_r[7];
        out_sh_r <= stat_l2_r[6:0];
      end else begin
        so_r     <= out_sh_r[6];
        out_sh_r <= {out_sh_r[5:0], 1'b0};
      end
    end
  end

  // ---------------- core side, clocked by clk ----------------
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic hold_s1_r, hold_s2_r;
  logic wp_s1_r, wp_s2_r;
  logic tgl_s1_r, tgl_s2_r;
  logic drv_s1_r, drv_s2_r;
  logic so_s1_r, so_s2_r;
  logic seen_tgl_r;
  logic seen_low_r;
  logic latch_r;
  logic [7:0] nv_r;
  logic [7:0] pend_r;
  sep_pkg::sep_state_t   state_r;
  sep_pkg::sep_state_t   state_nxt;
  sep_pkg::sep_wr_kind_t kind_r;

  // select, pause and protect pins and the toggle, drive and output link flops pass two stages first; frame results are read direct
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      hold_s1_r <= 1'b1;
      hold_s2_r <= 1'b1;
      wp_s1_r   <= 1'b1;
      wp_s2_r   <= 1'b1;
      tgl_s1_r  <= 1'b0;
      tgl_s2_r  <= 1'b0;
      drv_s1_r  <= 1'b0;
      drv_s2_r  <= 1'b0;
      so_s1_r   <= 1'b0;
      so_s2_r   <= 1'b0;
    end else begin
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      hold_s1_r <= hold_n;
      hold_s2_r <= hold_s1_r;
      wp_s1_r   <= wp_n;
      wp_s2_r   <= wp_s1_r;
      tgl_s1_r  <= frame_tgl_r;
      tgl_s2_r  <= tgl_s1_r;
      drv_s1_r  <= drive_r;
      drv_s2_r  <= drv_s1_r;
      so_s1_r   <= so_r;
      so_s2_r   <= so_s1_r;
    end
  end

  sep_tmr_if tif ();

  sep_wtimer #(
    .CYCLES (WR_CYCLES)
  ) u_tmr (
    .clk  (clk),
    .rstn (rstn),
    .tif  (tif)
  );

  // frame results are stable once the select rise is seen here, since the
  // host stops the serial clock while deselected
  wire cs_rise   = cs_s2_r && !cs_s3_r;
  wire new_frame = (tgl_s2_r != seen_tgl_r);
  wire commit    = cs_rise && new_frame && seen_low_r;
  wire whole     = (bit_r == 3'h0);
  wire idle      = (state_r == sep_pkg::SEP_IDLE);
  wire honor     = nv_r[`SEP_ST_HONOR];
  wire guard     = honor && !wp_s2_r;

  wire is_set    = (op_r == `SEP_OP_LATCH_SET) && (byte_r == 3'h1) && whole;
  wire is_clr    = (op_r == `SEP_OP_LATCH_CLR) && (byte_r == 3'h1) && whole;
  wire is_swr    = (op_r == `SEP_OP_STAT_WR) && (byte_r == `SEP_BYTES_STAT_WR)
                   && whole;
  wire is_awr    = (op_r == `SEP_OP_ARRAY_WR) && (byte_r >= `SEP_BYTES_ARR_MIN)
                   && whole;
  wire go_swr    = commit && idle && latch_r && is_swr && !guard;
  wire drop_swr  = commit && idle && latch_r && is_swr && guard;
  wire go_awr    = commit && idle && latch_r && is_awr;
  wire go_any    = go_swr || go_awr;
  // busy counts from the accepting clock, so the status bit never lags the port
  wire wip       = !idle || go_any;

  assign tif.start = go_any;

  // select is not read here: a started cycle leaves only through done
  always_comb begin
    unique case (state_r)
      sep_pkg::SEP_IDLE: state_nxt = go_any ? sep_pkg::SEP_BUSY : sep_pkg::SEP_IDLE;
      sep_pkg::SEP_BUSY: state_nxt = tif.done ? sep_pkg::SEP_DONE : sep_pkg::SEP_BUSY;
      sep_pkg::SEP_DONE: state_nxt = sep_pkg::SEP_IDLE;
      default:           state_nxt = sep_pkg::SEP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= sep_pkg::SEP_IDLE;
      seen_tgl_r <= 1'b0;
      seen_low_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      seen_tgl_r <= cs_rise ? tgl_s2_r : seen_tgl_r;
      seen_low_r <= seen_low_r || !cs_s2_r;
    end
  end

  // protect pin is looked at only at commit; later changes are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      kind_r <= sep_pkg::SEP_WR_NONE;
      pend_r <= 8'h00;
    end else if (go_any) begin
      kind_r <= go_swr ? sep_pkg::SEP_WR_STATUS : sep_pkg::SEP_WR_ARRAY;
      pend_r <= sdat_r;
    end
  end

  // status bits land when the cycle ends; latch clears then as well
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_r    <= ST_INIT;
      latch_r <= 1'b0;
    end else begin
      if (state_r == sep_pkg::SEP_DONE && kind_r == sep_pkg::SEP_WR_STATUS) begin
        nv_r[`SEP_ST_HONOR]                 <= pend_r[`SEP_ST_HONOR];
        nv_r[`SEP_ST_BP_HI:`SEP_ST_BP_LO]   <= pend_r[`SEP_ST_BP_HI:`SEP_ST_BP_LO];
      end
      if (state_r == sep_pkg::SEP_DONE || (commit && idle && is_clr)) begin
        latch_r <= 1'b0;
      end else if (commit && idle && is_set) begin
        latch_r <= 1'b1;
      end
    end
  end

  wire [7:0] status_nxt = {nv_r[`SEP_ST_HONOR], 3'h0,
                           nv_r[`SEP_ST_BP_HI:`SEP_ST_BP_LO], latch_r, wip};

  // word for the link frozen while selected, so a read never sees it tear;
  // limitation: a read shows the busy bit as it stood at the select fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_frz_r <= `SEP_ST_RESET;
    end else if (cs_s2_r) begin
      stat_frz_r <= status_nxt;
    end
  end

  // outputs, each from its own flop; release of the line lags the pins by
  // the two-stage catch, a few core clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_o           <= 1'b0;
      so_oe          <= 1'b0;
      standby        <= 1'b1;
      busy           <= 1'b0;
      array_write_go <= 1'b0;
      status_refused <= 1'b0;
      status_o       <= 8'h00;
    end else begin
      so_o           <= so_s2_r;
      so_oe          <= drv_s2_r && !cs_s2_r && hold_s2_r;
      standby        <= cs_s2_r && idle && !go_any;
      busy           <= wip;
      array_write_go <= go_awr;
      status_refused <= drop_swr;
      status_o       <= status_nxt;
    end
  end
endmodule

// file: hdl/sep_defs.svh
// constants for the serial eeprom select and protect block
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

`define SEP_OP_W          8
`define SEP_OP_LATCH_SET  8'h06
`define SEP_OP_LATCH_CLR  8'h04
`define SEP_OP_STAT_WR    8'h01
`define SEP_OP_STAT_RD    8'h05
`define SEP_OP_ARRAY_WR   8'h02

`define SEP_ST_HONOR      7
`define SEP_ST_BP_HI      3
`define SEP_ST_BP_LO      2
`define SEP_ST_LATCH      1
`define SEP_ST_BUSY       0
`define SEP_ST_RESET      8'h00

`define SEP_BYTES_STAT_WR 3'h2
`define SEP_BYTES_ARR_MIN 3'h4
`define SEP_BYTES_MAX     3'h7

`define SEP_TWC_MS        5
`define SEP_CLK_HZ        40000000
`define SEP_MS_PER_S      1000
`define SEP_TWC_CYCLES    (`SEP_TWC_MS * (`SEP_CLK_HZ / `SEP_MS_PER_S))
`define SEP_TMR_W         18

`endif

// file: hdl/sep_pkg.sv
// types shared by the serial eeprom select and protect block
package sep_pkg;
  typedef enum logic [1:0] {
    SEP_IDLE = 2'b00,
    SEP_BUSY = 2'b01,
    SEP_DONE = 2'b10
  } sep_state_t;

  typedef enum logic [1:0] {
    SEP_WR_NONE   = 2'b00,
    SEP_WR_STATUS = 2'b01,
    SEP_WR_ARRAY  = 2'b10
  } sep_wr_kind_t;
endpackage

// file: hdl/sep_tmr_if.sv
// start and busy handshake between the control logic and the write timer
`timescale 1ns/100ps
interface sep_tmr_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport tmr  (input start, output busy, output done);
endinterface

// file: hdl/sep_wtimer.sv
// self-timed write cycle counter
`timescale 1ns/100ps
`include "sep_defs.svh"
module sep_wtimer #(
  parameter int unsigned CYCLES = `SEP_TWC_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  sep_tmr_if.tmr    tif
);
  localparam int unsigned TW = $clog2(CYCLES + 1);

  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic          busy_r;
  wire           last = busy_r && (cnt_r == TW'(CYCLES - 1));

  // a start while busy is dropped; a started cycle always runs out
  assign cnt_nxt = busy_r ? (last ? '0 : cnt_r + TW'(1)) : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_r ? !last : tif.start;
    end
  end

  // done marks the last count cycle itself; a flopped copy would stretch busy
  assign tif.busy = busy_r;
  assign tif.done = last;
endmodule

// file: dv/sep_host.sv
// spi host model driving select, serial clock, data and pause pins
`timescale 1ns/100ps
module sep_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_o,
  input  wire logic so_oe
);
  // clock parked low outside frames, select idle high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic bit_out(input logic b);
    si = b;
    #40 sck = 1'b1;
    #40 sck = 1'b0;
  endtask
  // select pulse with no clock; the core must see it low
  task automatic blip();
    cs_n = 1'b0;
    #75 cs_n = 1'b1;
    #75;
  endtask
  task automatic frame(input logic [7:0] q[$]);
    cs_n = 1'b0;
    #40;
    foreach (q[i]) for (int j = 7; j >= 0; j--) bit_out(q[i][j]);
    cs_n = 1'b1;
    si = ~si; // released line must not keep its value
    #200;
  endtask
  task automatic read_status(output logic [7:0] rd, output logic oe1, output logic oeh);
    logic [7:0] opc;
    opc = 8'h05;
    cs_n = 1'b0;
    #40;
    for (int j = 7; j >= 0; j--) bit_out(opc[j]);
    for (int j = 7; j >= 0; j--) begin
      si = ~si;
      #40 sck = 1'b1;
      // sampled late: output lags the falling edge by a few core clocks
      #38 rd[j] = so_o;
      if (j == 7) oe1 = so_oe;
      #2 sck = 1'b0;
      if (j == 4) begin
        #10 hold_n = 1'b0;
        #300 oeh = so_oe;
        hold_n = 1'b1;
        #10;
      end
    end
    #40 cs_n = 1'b1;
    #200;
  endtask
endmodule

// file: dv/sep_assertions.sv
// concurrent checks on the select, drive and protect ports
`timescale 1ns/100ps
module sep_assertions #(
  parameter int unsigned WR_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       hold_n,
  input wire logic       wp_n,
  input wire logic       so_o,
  input wire logic       so_oe,
  input wire logic       standby,
  input wire logic       busy,
  input wire logic       array_write_go,
  input wire logic       status_refused,
  input wire logic [7:0] status_o
);
  int unsigned busy_len_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busy_len_r <= 0;
    else busy_len_r <= busy ? busy_len_r + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_busy_within_limit: assert property (busy_len_r <= WR_CYCLES + 2)
    else $error("write cycle too long");
  a_busy_no_standby: assert property (busy && $past(busy) |-> !standby)
    else $error("standby during write cycle");
  a_standby_after_wr: assert property ((cs_n && !busy) [*6] |=> standby)
    else $error("no standby when idle and deselected");
  a_float_desel: assert property (cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
  a_float_pause: assert property ((!hold_n) [*5] |-> !so_oe)
    else $error("output driven while paused");
  a_go_starts_busy: assert property (array_write_go |-> $rose(busy))
    else $error("array write without write cycle");
  a_refused_idle: assert property (status_refused |-> !busy ##1 !busy)
    else $error("refused write started a cycle");
  a_busy_holds: assert property ($rose(busy) |=> busy [*8])
    else $error("write cycle cut short");
  a_busy_bit: assert property (status_o[0] == busy)
    else $error("status busy bit differs from busy");
  a_status_steady: assert property (!busy && !$past(busy) |-> $stable(status_o[7:2]))
    else $error("status bits changed without write cycle");
endmodule
bind sep_top sep_assertions #(.WR_CYCLES(WR_CYCLES)) chk_u (.clk(clk), .rstn(rstn), .sck(sck),
  .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe),
  .standby(standby), .busy(busy), .array_write_go(array_write_go),
  .status_refused(status_refused), .status_o(status_o));

// file: dv/test_sep_top.sv
// self-checking bench for the select, drive and protect block
`timescale 1ns/100ps
module test_sep_top;
  localparam int unsigned WRC = 40;
  logic       clk, rstn, sck, cs_n, si, hold_n, wp_n, so_o, so_oe;
  logic       standby, busy, go, refused, oe1, oeh;
  logic [7:0] st, rd;
  int         fails, checks, n_go, n_ref, n_busy;
  sep_top #(.WR_CYCLES(WRC)) dut_u (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .standby(standby), .busy(busy),
    .array_write_go(go), .status_refused(refused), .status_o(st));
  sep_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o),
    .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (go === 1'b1) n_go++;
    if (refused === 1'b1) n_ref++;
    if (busy === 1'b1) n_busy++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for the write cycle to end
  task automatic wait_done();
    repeat (2) @(negedge clk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  task automatic wr_seq(input logic [7:0] q[$]);
    host_u.frame({8'h06});
    host_u.frame(q);
    wait_done();
  endtask
  task automatic t_reset();
    check("standby", standby, 8'h01);
    check("so_oe", so_oe, 8'h00);
    check("status", st, 8'h00);
  endtask
  task automatic t_stat_wr();
    n_busy = 0;
    host_u.frame({8'h06});
    host_u.frame({8'h01, 8'h8c});
    check("busy", busy, 8'h01);
    host_u.blip();
    check("busy", busy, 8'h01);
    check("standby", standby, 8'h00);
    wait_done();
    check("busy_len", 8'(n_busy), 8'(WRC + 2));
    check("status", st, 8'h8c);
    check("standby", standby, 8'h01);
  endtask
  task automatic t_protect();
    @(negedge clk) wp_n = 1'b0;
    n_ref = 0;
    n_go = 0;
    wr_seq({8'h01, 8'h00});
    check("refused", 8'(n_ref), 8'h01);
    check("status", st, 8'h8e);
    wr_seq({8'h02, 8'h00, 8'h10, 8'h5a});
    check("go", 8'(n_go), 8'h01);
    check("status", st, 8'h8c);
    @(negedge clk) wp_n = 1'b1;
    host_u.frame({8'h06});
    host_u.frame({8'h01, 8'h00});
    @(negedge clk) wp_n = 1'b0;
    wait_done();
    check("status", st, 8'h00);
  endtask
  task automatic t_honor_clr();
    wr_seq({8'h01, 8'h0c});
    check("status", st, 8'h0c);
  endtask
  task automatic t_latch_clr();
    n_busy = 0;
    host_u.frame({8'h06});
    check("latch", st, 8'h0e);
    host_u.frame({8'h04});
    check("latch", st, 8'h0c);
    host_u.frame({8'h01, 8'h80});
    wait_done();
    check("busy_len", 8'(n_busy), 8'h00);
    check("status", st, 8'h0c);
  endtask
  task automatic t_read();
    host_u.read_status(rd, oe1, oeh);
    check("read", rd, 8'h0c);
    check("oe_read", oe1, 8'h01);
    check("oe_pause", oeh, 8'h00);
    repeat (6) @(negedge clk);
    check("so_oe", so_oe, 8'h00);
  endtask
  initial begin
    wp_n = 1'b1;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    host_u.blip();
    t_stat_wr();
    t_protect();
    t_honor_clr();
    t_latch_clr();
    t_read();
    wrap_up();
  end
  // whole run needs well under 0.2 ms
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
endmodule
